// File: src/vic_ctrl.sv
/*
  vic_ctrl: vectored, maskable, eight-level priority interrupt controller.
  assumes: all source lines and bus strobes are synchronous to sys_clk_in;
  the core reads the vector register on entry and writes end-of-service on exit.
*/
// The register addresses and the plain strobed port were decided locally.
// Summary of operation
// - thirty-two maskable vectored sources, eight priorities
// - drive active-low fast and standard requests
// - higher priority preempts one in service
// - internal sources level or edge sensed
// - external sources rise, fall, high, low
// - fast forcing routes any source to fast
// - source zero is the fast pin
// - source one ORs system peripheral lines
// - sources two to thirty-one peripheral lines
// - peripheral id equals source number
// - always clocked, no clock gating
// - any request wakes idle core
// - general mask wakes without raising requests
// - priority zero lowest, seven highest
// - ties go to lowest source number
// - vector read clears current unless fast-forced
// - eight-deep stack pushed on read, popped
`timescale 1ns/10ps
`default_nettype none
module vic_ctrl
  import vic_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic fast_irq_pin_in,
  input wire logic [SYS_LINES-1:0] system_irq_lines_in,
  input wire logic [NSRC-1:2] periph_irq_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic fast_req_out_n,
  output logic std_req_out_n,
  output logic wake_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  vic_state_t state_reg;
  vic_state_t state_next;

  logic [NSRC-1:0] raw_src;
  logic [NSRC-1:0] edge_mode;
  logic [NSRC-1:0] level_act;
  logic [NSRC-1:0] edge_hit;
  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] std_cand;
  logic fast_act;
  logic [SRC_W-1:0] win_src;
  logic [PRIO_W-1:0] win_prio;
  logic win_any;
  logic [SP_W-1:0] top_idx;
  vic_stk_ent_t cur_ent;
  logic irq_pend;
  logic mode_region;
  logic vect_region;
  logic [SRC_W-1:0] reg_idx;
  logic ram_we;
  logic ram_re;
  logic [SRC_W-1:0] ram_raddr;
  logic [DATA_W-1:0] rd_alt;
  logic ivr_rd;
  logic fvr_rd;
  logic wr_mode;
  logic wr_set_cmd;
  logic wr_clr_cmd;
  logic wr_en_cmd;
  logic wr_dis_cmd;
  logic wr_fen_cmd;
  logic wr_fdis_cmd;
  logic wr_spur;
  logic wr_gen;
  logic wr_eos;
  logic stk_empty;
  logic stk_full;

  // ****************************************************************
  // source assembly
  // ****************************************************************
  // source index doubles as the peripheral id
  assign raw_src = {periph_irq_in, |system_irq_lines_in, fast_irq_pin_in};

  // ****************************************************************
  // input stage per source
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++)
    begin : g_src
      logic act_high;
      // internal lines have no polarity choice: only edge or level
      assign act_high = EXT_SRC_MASK[gi] ? state_reg.sense[gi][1] : 1'b1;
      assign edge_mode[gi] = state_reg.sense[gi][0];
      assign level_act[gi] = act_high ? state_reg.sync2[gi] : ~state_reg.sync2[gi];
      assign edge_hit[gi] = act_high ? (state_reg.sync2[gi] & ~state_reg.prev[gi]) :
                                       (~state_reg.sync2[gi] & state_reg.prev[gi]);
      assign pending[gi] = edge_mode[gi] ? state_reg.edge_lat[gi] : level_act[gi];
    end
  endgenerate

  // ****************************************************************
  // priority resolution
  // ****************************************************************
  // source 0 and fast-forced sources never compete for the standard line
  assign std_cand = pending & state_reg.enable & ~state_reg.fast_en & ~SRC0_BIT;
  assign fast_act = |(pending & state_reg.enable & (state_reg.fast_en | SRC0_BIT));

  always_comb
  begin
    win_src = '0;
    win_prio = '0;
    win_any = 1'b0;
    // walk downward with >= so the lowest number wins a tie
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (std_cand[i] && (!win_any || state_reg.prio[i] >= win_prio))
      begin
        win_src = SRC_W'(i);
        win_prio = state_reg.prio[i];
        win_any = 1'b1;
      end
    end
  end

  // a full stack refuses the push; an empty one turns end-of-service into a no-op
  assign stk_empty = (state_reg.sp == '0);
  assign stk_full = (state_reg.sp == SP_W'(STK_DEPTH));
  assign top_idx = state_reg.sp - 4'h1;
  assign cur_ent = !stk_empty ? state_reg.stack[top_idx[2:0]] : '0;
  // only a strictly higher level may interrupt the one in service
  assign irq_pend = win_any && (stk_empty || (win_prio > cur_ent.prio));

  // ****************************************************************
  // register port decode
  // ****************************************************************
  assign mode_region = (addr_in[8:7] == REGION_MODE);
  assign vect_region = (addr_in[8:7] == REGION_VECT);
  assign reg_idx = addr_in[6:2];
  assign ivr_rd = rd_in && (addr_in == OFS_VECTOR_READ);
  assign fvr_rd = rd_in && (addr_in == OFS_FAST_VECTOR);
  assign ram_we = wr_in && vect_region;

  // ****************************************************************
  // write strobe decode
  // ****************************************************************
  // one strobe per command word; unmapped offsets raise none of them
  assign wr_mode = wr_in && mode_region;
  assign wr_set_cmd = wr_in && (addr_in == OFS_SET_CMD);
  assign wr_clr_cmd = wr_in && (addr_in == OFS_CLEAR_CMD);
  assign wr_en_cmd = wr_in && (addr_in == OFS_ENABLE_CMD);
  assign wr_dis_cmd = wr_in && (addr_in == OFS_DISABLE_CMD);
  assign wr_fen_cmd = wr_in && (addr_in == OFS_FAST_EN_CMD);
  assign wr_fdis_cmd = wr_in && (addr_in == OFS_FAST_DIS_CMD);
  assign wr_spur = wr_in && (addr_in == OFS_SPURIOUS);
  assign wr_gen = wr_in && (addr_in == OFS_GEN_CTRL);
  assign wr_eos = wr_in && (addr_in == OFS_END_OF_SERVICE);

  always_comb
  begin
    ram_re = 1'b0;
    ram_raddr = reg_idx;
    if (rd_in && vect_region)
    begin
      ram_re = 1'b1;
    end
    else if (ivr_rd && irq_pend)
    begin
      ram_re = 1'b1;
      ram_raddr = win_src;
    end
    else if (fvr_rd && fast_act)
    begin
      ram_re = 1'b1;
      ram_raddr = '0;
    end
  end

  always_comb
  begin
    rd_alt = '0;
    if (mode_region)
    begin
      rd_alt[SMR_PRIO_LSB +: PRIO_W] = state_reg.prio[reg_idx];
      rd_alt[SMR_SENSE_LSB +: 2] = state_reg.sense[reg_idx];
    end
    else
    begin
      case (addr_in)
        OFS_VECTOR_READ: rd_alt = state_reg.spur_vec;
        OFS_FAST_VECTOR: rd_alt = state_reg.spur_vec;
        OFS_CUR_SOURCE: rd_alt[SRC_W-1:0] = cur_ent.src;
        OFS_PENDING: rd_alt = pending;
        OFS_MASK: rd_alt = state_reg.enable;
        OFS_CORE_STATUS:
        begin
          rd_alt[CISR_STD_BIT] = ~state_reg.std_n;
          rd_alt[CISR_FAST_BIT] = ~state_reg.fast_n;
        end
        OFS_SPURIOUS: rd_alt = state_reg.spur_vec;
        OFS_GEN_CTRL: rd_alt[GEN_MASK_BIT] = state_reg.gen_mask;
        OFS_FAST_STATUS: rd_alt = state_reg.fast_en;
        default: rd_alt = '0;
      endcase
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [NSRC-1:0] set_v;
    logic [NSRC-1:0] clr_v;
    vic_stk_ent_t push_ent;
    set_v = '0;
    clr_v = '0;
    push_ent = '0;
    state_next = state_reg;

    // two flops per line before any detector looks at it
    state_next.sync1 = raw_src;
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;

    set_v = edge_hit;
    if (wr_set_cmd)
    begin
      set_v = set_v | wdata_in;
    end
    if (wr_clr_cmd)
    begin
      clr_v = clr_v | wdata_in;
    end

    if (wr_mode)
    begin
      state_next.prio[reg_idx] = wdata_in[SMR_PRIO_LSB +: PRIO_W];
      state_next.sense[reg_idx] = vic_sense_t'(wdata_in[SMR_SENSE_LSB +: 2]);
    end

    if (wr_en_cmd)
    begin
      state_next.enable = state_reg.enable | wdata_in;
    end
    if (wr_dis_cmd)
    begin
      state_next.enable = state_reg.enable & ~wdata_in;
    end
    if (wr_fen_cmd)
    begin
      state_next.fast_en = state_reg.fast_en | wdata_in;
    end
    if (wr_fdis_cmd)
    begin
      state_next.fast_en = state_reg.fast_en & ~wdata_in;
    end
    if (wr_spur)
    begin
      state_next.spur_vec = wdata_in;
    end
    if (wr_gen)
    begin
      state_next.gen_mask = wdata_in[GEN_MASK_BIT];
    end

    // entry: winner becomes current, its edge memory is consumed
    if (ivr_rd && irq_pend && !stk_full)
    begin
      push_ent.src = win_src;
      push_ent.prio = win_prio;
      state_next.stack[state_reg.sp[2:0]] = push_ent;
      state_next.sp = state_reg.sp + 4'h1;
      if (!state_reg.fast_en[win_src])
      begin
        clr_v[win_src] = 1'b1;
      end
    end
    if (fvr_rd && fast_act)
    begin
      clr_v[0] = 1'b1;
    end

    // exit: previous level resurfaces from the stack
    if (wr_eos && !stk_empty)
    begin
      state_next.sp = state_reg.sp - 4'h1;
    end

    // set beats clear; level-sensed sources ignore both
    state_next.edge_lat = edge_mode & ((state_reg.edge_lat & ~clr_v) | set_v);

    // general mask holds the lines quiet but still wakes the core
    state_next.fast_n = ~(fast_act & ~state_reg.gen_mask);
    state_next.std_n = ~(irq_pend & ~state_reg.gen_mask);
    state_next.wake = fast_act | irq_pend;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // runs on the free system clock; no gating input exists here
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= '0;
      state_reg.fast_n <= 1'b1;
      state_reg.std_n <= 1'b1;
      state_reg.spur_vec <= RST_SPURIOUS;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // vector store and read data
  // ****************************************************************
  // every read, array or not, leaves through the store's output flop
  vic_vec_ram u_vec_ram (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .we_in(ram_we),
    .waddr_in(reg_idx),
    .wdata_in(wdata_in),
    .re_in(ram_re),
    .raddr_in(ram_raddr),
    .alt_in(rd_alt),
    .q_out(rdata_out)
  );

  assign fast_req_out_n = state_reg.fast_n;
  assign std_req_out_n = state_reg.std_n;
  assign wake_out = state_reg.wake;

endmodule : vic_ctrl
`default_nettype wire

// File: src/vic_pkg.sv
/*
  vic_pkg: constants, field positions, sense modes and state types of the
  vectored interrupt controller.
  assumes: one 200 MHz system clock, 32-bit register port with byte addresses.
*/
`default_nettype none
package vic_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NSRC = 32;
  localparam int PRIO_W = 3;
  localparam int SRC_W = 5;
  localparam int STK_DEPTH = 8;
  localparam int SP_W = 4;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int SYS_LINES = 4;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [1:0] REGION_MODE = 2'h0;
  localparam logic [1:0] REGION_VECT = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_VECTOR_READ = 9'h100;
  localparam logic [ADDR_W-1:0] OFS_FAST_VECTOR = 9'h104;
  localparam logic [ADDR_W-1:0] OFS_CUR_SOURCE = 9'h108;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 9'h10c;
  localparam logic [ADDR_W-1:0] OFS_MASK = 9'h110;
  localparam logic [ADDR_W-1:0] OFS_CORE_STATUS = 9'h114;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CMD = 9'h120;
  localparam logic [ADDR_W-1:0] OFS_DISABLE_CMD = 9'h124;
  localparam logic [ADDR_W-1:0] OFS_CLEAR_CMD = 9'h128;
  localparam logic [ADDR_W-1:0] OFS_SET_CMD = 9'h12c;
  localparam logic [ADDR_W-1:0] OFS_END_OF_SERVICE = 9'h130;
  localparam logic [ADDR_W-1:0] OFS_SPURIOUS = 9'h134;
  localparam logic [ADDR_W-1:0] OFS_GEN_CTRL = 9'h138;
  localparam logic [ADDR_W-1:0] OFS_FAST_EN_CMD = 9'h140;
  localparam logic [ADDR_W-1:0] OFS_FAST_DIS_CMD = 9'h144;
  localparam logic [ADDR_W-1:0] OFS_FAST_STATUS = 9'h148;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int SMR_PRIO_LSB = 0;
  localparam int SMR_SENSE_LSB = 5;
  localparam int GEN_MASK_BIT = 1;
  localparam int CISR_STD_BIT = 1;
  localparam int CISR_FAST_BIT = 0;
  localparam logic [NSRC-1:0] EXT_SRC_MASK = 32'he000_0001;
  localparam logic [NSRC-1:0] SRC0_BIT = 32'h0000_0001;
  localparam logic [DATA_W-1:0] RST_SPURIOUS = 32'h0000_0000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_FALL = 2'b01,
    SENSE_HIGH = 2'b10,
    SENSE_RISE = 2'b11
  } vic_sense_t;

  typedef struct packed {
    logic [SRC_W-1:0] src;
    logic [PRIO_W-1:0] prio;
  } vic_stk_ent_t;

  typedef struct packed {
    logic [NSRC-1:0] sync1;
    logic [NSRC-1:0] sync2;
    logic [NSRC-1:0] prev;
    logic [NSRC-1:0] edge_lat;
    logic [NSRC-1:0] enable;
    logic [NSRC-1:0] fast_en;
    logic [NSRC-1:0][PRIO_W-1:0] prio;
    vic_sense_t [NSRC-1:0] sense;
    vic_stk_ent_t [STK_DEPTH-1:0] stack;
    logic [SP_W-1:0] sp;
    logic gen_mask;
    logic [DATA_W-1:0] spur_vec;
    logic fast_n;
    logic std_n;
    logic wake;
  } vic_state_t;

endpackage : vic_pkg
`default_nettype wire

// File: src/vic_vec_ram.sv
/*
  vic_vec_ram: handler vector store, one word per source, registered read.
  assumes: one write port, one read port; q_out loads alt_in when no array
  read is requested, so the caller can route any register through it.
*/
`timescale 1ns/10ps
`default_nettype none
module vic_vec_ram
  import vic_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic we_in,
  input wire logic [SRC_W-1:0] waddr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic re_in,
  input wire logic [SRC_W-1:0] raddr_in,
  input wire logic [DATA_W-1:0] alt_in,
  output logic [DATA_W-1:0] q_out
);

  // array is not reset: vectors are undefined until software loads them
  logic [DATA_W-1:0] mem_reg [NSRC];

  always_ff @(posedge sys_clk_in)
  begin
    if (we_in)
    begin
      mem_reg[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      q_out <= '0;
    end
    else
    begin
      q_out <= re_in ? mem_reg[raddr_in] : alt_in;
    end
  end

endmodule : vic_vec_ram
`default_nettype wire

// File: testbench/vic_core_model.sv
/*
  vic_core_model: idle processor core facing the request lines.
  assumes: sits on the controller clock; starts idle after reset.
*/
`timescale 1ns/10ps
`default_nettype none
module vic_core_model
  import vic_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic fast_n_in,
  input wire logic std_n_in,
  input wire logic wake_in,
  input wire logic sleep_in,
  output logic awake_out
);
  // once woken the core keeps running until the bench parks it again
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      awake_out <= 1'b0;
    end
    else if (sleep_in)
    begin
      awake_out <= 1'b0;
    end
    else if (wake_in || !fast_n_in || !std_n_in)
    begin
      awake_out <= 1'b1;
    end
  end
endmodule : vic_core_model
`default_nettype wire

// File: testbench/vic_ctrl_bench.sv
/*
  vic_ctrl_bench: self-checking bench for vic_ctrl.
  assumes: register offsets and sense codes of vic_pkg.
*/
`timescale 1ns/10ps
`default_nettype none
module vic_ctrl_bench
  import vic_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic [3:0] system_irq_source = 4'h0;
  logic [31:2] per = 30'h0;
  logic [8:0] addr = 9'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q, r;
  logic fq_n, sq_n, wake, awake;
  logic [31:0] vec [32];
  int mismatches = 0;
  int check_count = 0;
  int seed = 19595;
  int cyc = 0;

  vic_ctrl u_dut (.sys_clk_in(clk), .rstn_in(rst_n), .fast_irq_pin_in(pin), .system_irq_lines_in(system_irq_source),
    .periph_irq_in(per), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .fast_req_out_n(fq_n), .std_req_out_n(sq_n), .wake_out(wake));
  vic_core_model u_core (.clk_in(clk), .rstn_in(rst_n), .fast_n_in(fq_n), .std_n_in(sq_n), .wake_in(wake),
    .sleep_in(sleep), .awake_out(awake));

  always #2.5 clk = ~clk;

  // ****
  // tasks
  // ****
  task automatic give_verdict;
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // pending of an external line once at its active level, and again once back
  // at idle: only the edge codes remember the event
  function automatic logic [31:0] ext_exp(input logic [1:0] m, input logic back_idle);
    ext_exp = {31'h0, back_idle ? m[0] : 1'b1};
  endfunction : ext_exp

  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // write then read with no gap between the strobes
  task automatic wr_rd(input logic [8:0] a, input logic [31:0] d, input logic [8:0] ra, output logic [31:0] o);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= ra;
    @(posedge clk);
    rd <= 1'b0;
    #1 o = rdata;
  endtask : wr_rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // ****
  // scenarios
  // ****
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // reset modes: internal lines high-level, external ones low-level
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      per <= r[31:2];
      system_irq_source <= r[4:1];
      pin <= r[0];
      settle(5);
      rd_reg(OFS_PENDING, q);
      chk(q, {~r[31:29], r[28:2], |r[4:1], ~r[0]});
    end
    per <= 30'h0;
    system_irq_source <= 4'h0;
    pin <= 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      vec[i] = $random(seed);
      wr_reg(9'h080 + 9'(4 * i), vec[i]);
      r = $random(seed);
      wr_rd(9'(4 * i), {29'h0, r[2:0]}, 9'(4 * i), q);
      chk({29'h0, q[2:0]}, {29'h0, r[2:0]});
    end
    wr_rd(OFS_ENABLE_CMD, 32'hffff_ffff, OFS_MASK, q);
    chk(q, 32'hffff_ffff);
    settle(5);
    chk({31'h0, sq_n}, 32'h0);
    wr_reg(OFS_DISABLE_CMD, 32'hffff_ffff);
    rd_reg(OFS_MASK, q);
    chk(q, 32'h0);
    // nesting: 9 at level 2 in service, then 12 and 20 tie at level 5
    wr_reg(9'h024, 32'h2);
    wr_reg(9'h030, 32'h5);
    wr_reg(9'h050, 32'h5);
    wr_reg(OFS_ENABLE_CMD, 32'h0010_1200);
    per[9] <= 1'b1;
    settle(5);
    chk({31'h0, sq_n}, 32'h0);
    rd_reg(OFS_VECTOR_READ, q);
    chk(q, vec[9]);
    settle(3);
    chk({31'h0, sq_n}, 32'h1);
    per[12] <= 1'b1;
    per[20] <= 1'b1;
    settle(5);
    chk({31'h0, sq_n}, 32'h0);
    rd_reg(OFS_VECTOR_READ, q);
    chk(q, vec[12]);
    wr_reg(OFS_END_OF_SERVICE, 32'h0);
    rd_reg(OFS_CUR_SOURCE, q);
    chk(q, 32'h9);
    per <= 30'h0;
    wr_reg(OFS_END_OF_SERVICE, 32'h0);
    wr_reg(OFS_DISABLE_CMD, 32'hffff_ffff);
    // edge source 15: latch, auto-clear, then fast forcing keeps it
    wr_reg(9'h03c, 32'h21);
    wr_reg(OFS_ENABLE_CMD, 32'h8000);
    per[15] <= 1'b1;
    settle(2);
    per[15] <= 1'b0;
    settle(5);
    rd_reg(OFS_PENDING, q);
    chk({31'h0, q[15]}, 32'h1);
    rd_reg(OFS_VECTOR_READ, q);
    chk(q, vec[15]);
    rd_reg(OFS_PENDING, q);
    chk({31'h0, q[15]}, 32'h0);
    wr_reg(OFS_END_OF_SERVICE, 32'h0);
    wr_reg(OFS_FAST_EN_CMD, 32'h8000);
    wr_reg(OFS_SET_CMD, 32'h8000);
    settle(5);
    chk({30'h0, fq_n, sq_n}, 32'h1);
    r = $random(seed);
    wr_reg(OFS_SPURIOUS, r);
    rd_reg(OFS_VECTOR_READ, q);
    chk(q, r);
    rd_reg(OFS_PENDING, q);
    chk({31'h0, q[15]}, 32'h1);
    wr_reg(OFS_CLEAR_CMD, 32'h8000);
    settle(5);
    chk({30'h0, fq_n, sq_n}, 32'h3);
    wr_reg(OFS_FAST_DIS_CMD, 32'h8000);
    // fast pin on source 0, low-level sense
    wr_reg(OFS_ENABLE_CMD, 32'h1);
    pin <= 1'b0;
    settle(5);
    chk({30'h0, fq_n, sq_n}, 32'h1);
    rd_reg(OFS_FAST_VECTOR, q);
    chk(q, vec[0]);
    pin <= 1'b1;
    wr_reg(OFS_DISABLE_CMD, 32'hffff_ffff);
    // external line 30 through all four sense codes
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(9'h078, {25'h0, 2'(m), 5'h3});
      per[30] <= ~m[1];
      settle(5);
      wr_reg(OFS_CLEAR_CMD, 32'h4000_0000);
      rd_reg(OFS_PENDING, q);
      chk({31'h0, q[30]}, 32'h0);
      per[30] <= m[1];
      settle(5);
      rd_reg(OFS_PENDING, q);
      chk({31'h0, q[30]}, ext_exp(2'(m), 1'b0));
      per[30] <= ~m[1];
      settle(5);
      rd_reg(OFS_PENDING, q);
      chk({31'h0, q[30]}, ext_exp(2'(m), 1'b1));
    end
    per[30] <= 1'b0;
    // park the core so that only the next wake can rouse it
    settle(5);
    sleep <= 1'b1;
    settle(1);
    sleep <= 1'b0;
    settle(1);
    chk({31'h0, awake}, 32'h0);
    // general mask: wake without request lines
    wr_reg(OFS_GEN_CTRL, 32'h2);
    wr_reg(OFS_ENABLE_CMD, 32'h200);
    per[9] <= 1'b1;
    settle(5);
    chk({29'h0, fq_n, sq_n, wake}, 32'h7);
    chk({31'h0, awake}, 32'h1);
    wr_reg(OFS_GEN_CTRL, 32'h0);
    settle(5);
    chk({29'h0, fq_n, sq_n, wake}, 32'h5);
    rd_reg(OFS_CORE_STATUS, q);
    chk(q, 32'h2);
    rd_reg(9'h1f0, q);
    chk(q, 32'h0);
    give_verdict();
  end
endmodule : vic_ctrl_bench
`default_nettype wire

// File: testbench/vic_ctrl_monitor.sv
/*
  vic_ctrl_monitor: port-level assertions for vic_ctrl.
  assumes: one clock domain, asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module vic_ctrl_monitor
  import vic_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic fast_req_out_n,
  input wire logic std_req_out_n,
  input wire logic wake_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // ****
  // assertions
  // ****
  // every enable resets to zero, so both lines stay quiet for three edges
  a_quiet_after_reset: assert property ($rose(rstn_in) |-> (fast_req_out_n && std_req_out_n && !wake_out) [*3])
    else $error("request active right after reset");
  a_wake_with_req: assert property ((!fast_req_out_n || !std_req_out_n) |-> wake_out)
    else $error("request without wake");
  a_unmapped_zero: assert property (rd_in && addr_in >= 9'h14c |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_status_image: assert property (rd_in && addr_in == OFS_CORE_STATUS |=>
    rdata_out == {30'h0, !$past(std_req_out_n), !$past(fast_req_out_n)})
    else $error("core status differs from request lines");
  a_disable_quiet: assert property (wr_in && addr_in == OFS_DISABLE_CMD && wdata_in == 32'hffff_ffff |->
    ##[1:3] (fast_req_out_n && std_req_out_n))
    else $error("request survives disabling all sources");
  a_gmask_quiet: assert property (wr_in && addr_in == OFS_GEN_CTRL && wdata_in[GEN_MASK_BIT] ##1
    !(wr_in && addr_in == OFS_GEN_CTRL) [*2] |-> fast_req_out_n && std_req_out_n)
    else $error("request under general mask");
  a_mask_readback: assert property (wr_in && addr_in == OFS_ENABLE_CMD ##1 rd_in && addr_in == OFS_MASK |=>
    (rdata_out & $past(wdata_in, 2)) == $past(wdata_in, 2))
    else $error("enable not seen in mask");
  a_prio_readback: assert property (wr_in && addr_in < 9'h080 ##1 rd_in && addr_in == $past(addr_in) |=>
    rdata_out[2:0] == $past(wdata_in[2:0], 2))
    else $error("priority readback wrong");
endmodule : vic_ctrl_monitor

bind vic_ctrl vic_ctrl_monitor u_mon (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .fast_req_out_n(fast_req_out_n), .std_req_out_n(std_req_out_n), .wake_out(wake_out));
`default_nettype wire
